// >>> rtl/tmrc_regs.vh
`ifndef TMRC_REGS_VH
`define TMRC_REGS_VH

// Register indices; byte address is four times the index
`define TMRC_IDX_DIRECTION      6'h00
`define TMRC_IDX_FORCE          6'h01
`define TMRC_IDX_OVR_MASK       6'h02
`define TMRC_IDX_OVR_DATA       6'h03
`define TMRC_IDX_COUNT_HIGH     6'h04
`define TMRC_IDX_COUNT_LOW      6'h05
`define TMRC_IDX_SYSCTL_ONE     6'h06
`define TMRC_IDX_OVF_TOGGLE     6'h07
`define TMRC_IDX_ACTION_HI      6'h08
`define TMRC_IDX_ACTION_LO      6'h09
`define TMRC_IDX_SYSCTL_TWO     6'h0D
`define TMRC_IDX_CHAN_FLAGS     6'h0E
`define TMRC_IDX_OVF_FLAGS      6'h0F
`define TMRC_IDX_CHAN_FIRST     6'h10
`define TMRC_IDX_CHAN_LAST      6'h1F
`define TMRC_IDX_ACC_FLAGS      6'h21
`define TMRC_IDX_ACC_COUNT_HIGH 6'h22
`define TMRC_IDX_ACC_COUNT_LOW  6'h23
`define TMRC_IDX_PIN_DISCONNECT 6'h2C
`define TMRC_IDX_PRECISION_PSC  6'h2E
`define TMRC_IDX_MODE_STATUS    6'h30

// System control one field positions
`define TMRC_SC1_ENABLE    7
`define TMRC_SC1_STOP_WAIT 6
`define TMRC_SC1_STOP_FRZ  5
`define TMRC_SC1_FAST_CLR  4
`define TMRC_SC1_PRECISION 3
`define TMRC_SC1_WR_MASK   8'hF8

// Reset values
`define TMRC_RESET_BYTE    8'h00
`define TMRC_RESET_COUNT   16'h0000

// Accumulator clock divide
`define TMRC_ACC_DIVIDE    64

`endif

// >>> rtl/tmrc_prescaler.v
`timescale 1ns/1ps
// Prescaler: emits a one-cycle tick every (divide) enabled clocks
module tmrc_prescaler #(
  parameter WIDTH = 9
) (
  input  wire             clk_in,
  input  wire             reset_in,
  input  wire             run_in,
  input  wire [WIDTH-1:0] divide_in,
  output wire             tick_out,
  output wire [WIDTH-1:0] phase_out
);
  reg [WIDTH-1:0] count_reg;
  wire            last;

  assign last      = (count_reg >= divide_in - {{(WIDTH-1){1'b0}}, 1'b1});
  assign tick_out  = run_in & last;
  assign phase_out = count_reg;

  // Free-running phase; a counter write does not restart it
  always @(posedge clk_in) begin
    if (reset_in) begin
      count_reg <= {WIDTH{1'b0}};
    end else if (run_in) begin
      if (last) begin
        count_reg <= {WIDTH{1'b0}};
      end else begin
        count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // tmrc_prescaler

// >>> rtl/tmrc_core.v
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
`include "tmrc_regs.vh"
// Operation
// - Channel-7 event overrides compare results on channels 7 to 0.
// - Masked channels follow override data bit on channel-7 event.
// - Unmasked channels never take override data on channel-7 event.
// - Override data reaches a pin only if compare mode and not disconnected.
// - Channel-7 event moves override data into port data, gated by mask.
// - Main counter is 16 bits and only counts up.
// - Counter writes ignored in normal mode, loaded only in special mode.
// - First count after a write may be short, never longer than one period.
// - Timer enable clear halts the whole timer including the counter.
// - Inactive timer stops the divide-by-64 accumulator clock.
// - Stop-in-wait halts timer and accumulator during wait mode.
// - Stop-in-freeze halts counter in freeze; accumulator clock continues.
// - Fast clear: capture read or compare write clears channel flag.
// - Fast clear: any counter byte access clears overflow flag.
// - Fast clear: accumulator count access clears accumulator flags.
// - Without fast clear, flags clear only by writing ones.
// - Precision bit selects eight-bit prescaler, else three-bit legacy field.
// - Only the first write to the precision bit after reset counts.
// - Toggle-on-overflow inverts compare-mode pin at each overflow.
// - Overflow toggle beats forced compare, yields to channel-7 override.
// - Unimplemented channel bits ignore writes and read zero, except the action-code pairs.
// - Forced compare beats real compare and leaves the flag clear.
// - Action code: 00 none, 01 toggle, 10 low, 11 high.
module tmrc_core #(
  parameter CHANNELS = 8
) (
  input  wire        clk_in,
  input  wire        reset_in,
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [7:0]  wb_adr_in,
  input  wire [3:0]  wb_sel_in,
  input  wire [31:0] wb_dat_in,
  output reg  [31:0] wb_dat_out,
  output wire        wb_ack_out,
  input  wire        special_mode_in,
  input  wire        wait_mode_in,
  input  wire        freeze_mode_in,
  input  wire [7:0]  capture_event_in,
  input  wire        acc_overflow_in,
  input  wire        acc_edge_in,
  output reg  [7:0]  port_data_out,
  output wire [7:0]  port_drive_out,
  output wire        acc_clock_out,
  output wire        counter_tick_out,
  output wire [15:0] main_counter_out
);
  localparam [7:0] IMPL = (CHANNELS >= 8) ? 8'hFF : ((8'h01 << CHANNELS) - 8'h01);
  localparam       HAS7 = (CHANNELS >= 8);

  reg  [7:0]  direction_reg;      // 1 = output compare
  reg  [7:0]  override_mask_reg;
  reg  [7:0]  override_data_reg;
  reg  [15:0] main_counter_reg;
  reg  [7:0]  system_control_one_reg;
  reg         precision_locked_reg;
  reg  [7:0]  overflow_toggle_reg;
  reg  [15:0] action_reg;         // {high pair byte, low pair byte}
  reg  [7:0]  system_control_two_reg;
  reg  [7:0]  channel_flag_reg;
  reg         counter_overflow_flag_reg;
  reg  [1:0]  accumulator_flag_reg;
  reg  [7:0]  pin_disconnect_reg;
  reg  [7:0]  precision_prescaler_reg;
  reg  [15:0] compare_reg [0:7];
  reg         ack_reg;
  reg  [7:0]  port_next;
  reg  [7:0]  force_mask;
  reg  [31:0] rd_next;
  wire [5:0]  idx;
  wire        req;
  wire        wr;
  wire        rd;
  wire        fast_clr;
  wire        timer_run;
  wire        count_run;
  wire        tick;
  wire        overflow;
  wire        ch7_event;
  wire [7:0]  compare_hit;
  wire [8:0]  divide;
  wire [8:0]  phase;
  integer     i;

  // Register index from byte address, word aligned
  assign idx        = wb_adr_in[7:2];
  assign req        = wb_cyc_in & wb_stb_in & ~ack_reg;
  assign wr         = req & wb_we_in & wb_sel_in[0];
  assign rd         = req & ~wb_we_in;
  assign wb_ack_out = ack_reg;
  assign fast_clr   = system_control_one_reg[`TMRC_SC1_FAST_CLR];

  assign timer_run = system_control_one_reg[`TMRC_SC1_ENABLE] &
                     ~(wait_mode_in & system_control_one_reg[`TMRC_SC1_STOP_WAIT]);
  assign count_run = timer_run &
                     ~(freeze_mode_in & system_control_one_reg[`TMRC_SC1_STOP_FRZ]);

  // Legacy field divides by powers of two
  function [8:0] legacy_div;
    input [2:0] code;
    begin
      legacy_div = 9'h001 << code;
    end
  endfunction

  assign divide = system_control_one_reg[`TMRC_SC1_PRECISION] ?
                  ({1'b0, precision_prescaler_reg} + 9'h001) :
                  legacy_div(system_control_two_reg[2:0]);

  tmrc_prescaler #(
    .WIDTH (9)
  ) u_prescaler (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .run_in    (timer_run),
    .divide_in (divide),
    .tick_out  (tick),
    .phase_out (phase)
  );

  // divide-by-64 only while active; wait stop also covers it
  reg [5:0] acc_div_reg;
  always @(posedge clk_in) begin
    if (reset_in) begin
      acc_div_reg <= 6'h00;
    end else if (timer_run) begin
      acc_div_reg <= acc_div_reg + 6'h01;
    end
  end
  assign acc_clock_out    = timer_run & (acc_div_reg == 6'h3F);
  assign counter_tick_out = tick & count_run;
  assign main_counter_out = main_counter_reg;

  assign overflow  = counter_tick_out & (main_counter_reg == 16'hFFFF);

  // Compare match when the counter steps onto the compare value
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gen_cmp
      assign compare_hit[g] = IMPL[g] & direction_reg[g] & counter_tick_out &
                              (main_counter_reg + 16'h0001 == compare_reg[g]);
    end
  endgenerate

  assign ch7_event = HAS7 & (compare_hit[7] | (overflow & overflow_toggle_reg[7]));

  // Pin action code decode
  // action code meaning
  function pin_action;
    input [1:0] code;
    input       cur;
    begin
      case (code)
        2'b01:   pin_action = ~cur;
        2'b10:   pin_action = 1'b0;
        2'b11:   pin_action = 1'b1;
        default: pin_action = cur;
      endcase
    end
  endfunction

  always @* begin
    force_mask = 8'h00;
    if (wr && idx == `TMRC_IDX_FORCE) begin
      force_mask = wb_dat_in[7:0] & IMPL;
    end
  end

  // Per-channel priority: override > toggle > forced > compare
  always @* begin
    port_next = port_data_out;
    for (i = 0; i < 8; i = i + 1) begin
      if (IMPL[i] && direction_reg[i]) begin
        if (force_mask[i] || compare_hit[i]) begin
          port_next[i] = pin_action(action_reg[2*i +: 2], port_data_out[i]);
        end
        if (overflow && overflow_toggle_reg[i]) begin
          port_next[i] = ~port_data_out[i];
        end
        if (ch7_event && override_mask_reg[i] && !pin_disconnect_reg[i]) begin
          port_next[i] = override_data_reg[i];
        end
      end
    end
  end
  assign port_drive_out = direction_reg & ~pin_disconnect_reg & IMPL;

  // Port data register
  always @(posedge clk_in) begin
    if (reset_in) begin
      port_data_out <= `TMRC_RESET_BYTE;
    end else begin
      port_data_out <= port_next;
    end
  end

  // Bus answer one cycle after request
  always @(posedge clk_in) begin
    if (reset_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  // Control registers
  // implemented-channel mask on writes
  always @(posedge clk_in) begin
    if (reset_in) begin
      direction_reg           <= `TMRC_RESET_BYTE;
      override_mask_reg       <= `TMRC_RESET_BYTE;
      override_data_reg       <= `TMRC_RESET_BYTE;
      system_control_one_reg  <= `TMRC_RESET_BYTE;
      precision_locked_reg    <= 1'b0;
      overflow_toggle_reg     <= `TMRC_RESET_BYTE;
      action_reg              <= `TMRC_RESET_COUNT;
      system_control_two_reg  <= `TMRC_RESET_BYTE;
      pin_disconnect_reg      <= `TMRC_RESET_BYTE;
      precision_prescaler_reg <= `TMRC_RESET_BYTE;
    end else if (wr) begin
      case (idx)
        `TMRC_IDX_DIRECTION:      direction_reg <= wb_dat_in[7:0] & IMPL;
        `TMRC_IDX_OVR_MASK:       override_mask_reg <= wb_dat_in[7:0] & IMPL;
        `TMRC_IDX_OVR_DATA:       override_data_reg <= wb_dat_in[7:0] & IMPL;
        `TMRC_IDX_OVF_TOGGLE:     overflow_toggle_reg <= wb_dat_in[7:0] & IMPL;
        `TMRC_IDX_PIN_DISCONNECT: pin_disconnect_reg <= wb_dat_in[7:0] & IMPL;
        `TMRC_IDX_PRECISION_PSC:  precision_prescaler_reg <= wb_dat_in[7:0];
        `TMRC_IDX_SYSCTL_TWO:     system_control_two_reg <= wb_dat_in[7:0] & 8'h8F;
        `TMRC_IDX_ACTION_HI:      action_reg[15:8] <= wb_dat_in[7:0];
        `TMRC_IDX_ACTION_LO:      action_reg[7:0] <= wb_dat_in[7:0];
        `TMRC_IDX_SYSCTL_ONE: begin
          system_control_one_reg[7:4] <= wb_dat_in[7:4];
          if (!precision_locked_reg) begin
            system_control_one_reg[`TMRC_SC1_PRECISION] <= wb_dat_in[`TMRC_SC1_PRECISION];
            precision_locked_reg <= 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // Compare registers, one 16-bit word per index pair
  always @(posedge clk_in) begin
    if (reset_in) begin
      for (i = 0; i < 8; i = i + 1) begin
        compare_reg[i] <= `TMRC_RESET_COUNT;
      end
    end else if (wr && idx >= `TMRC_IDX_CHAN_FIRST && idx <= `TMRC_IDX_CHAN_LAST &&
                 IMPL[idx[3:1]]) begin
      if (idx[0]) begin
        compare_reg[idx[3:1]][7:0] <= wb_dat_in[7:0];
      end else begin
        compare_reg[idx[3:1]][15:8] <= wb_dat_in[7:0];
      end
    end
  end

  always @(posedge clk_in) begin
    if (reset_in) begin
      main_counter_reg <= `TMRC_RESET_COUNT;
    end else if (wr && special_mode_in && idx == `TMRC_IDX_COUNT_HIGH) begin
      main_counter_reg[15:8] <= wb_dat_in[7:0];
    end else if (wr && special_mode_in && idx == `TMRC_IDX_COUNT_LOW) begin
      main_counter_reg[7:0] <= wb_dat_in[7:0];
    end else if (counter_tick_out) begin
      main_counter_reg <= main_counter_reg + 16'h0001;
    end
  end

  // Flags; a set in the same cycle as a clear wins
  wire       ch_range = req && idx >= `TMRC_IDX_CHAN_FIRST && idx <= `TMRC_IDX_CHAN_LAST;
  wire [7:0] ch_sel   = 8'h01 << idx[3:1];
  reg  [7:0] chan_clr;
  reg        ovf_clr;
  reg  [1:0] acc_clr;
  always @* begin
    chan_clr = 8'h00;
    ovf_clr  = 1'b0;
    acc_clr  = 2'b00;
    if (wr && idx == `TMRC_IDX_CHAN_FLAGS) chan_clr = wb_dat_in[7:0];
    if (wr && idx == `TMRC_IDX_OVF_FLAGS)  ovf_clr  = wb_dat_in[7];
    if (wr && idx == `TMRC_IDX_ACC_FLAGS)  acc_clr  = wb_dat_in[1:0];
    if (fast_clr) begin
      if (ch_range && ((rd && !direction_reg[idx[3:1]]) ||
                       (wr && direction_reg[idx[3:1]]))) begin
        chan_clr = chan_clr | ch_sel;
      end
      if (req && (idx == `TMRC_IDX_COUNT_HIGH || idx == `TMRC_IDX_COUNT_LOW)) begin
        ovf_clr = 1'b1;
      end
      if (HAS7 && req && (idx == `TMRC_IDX_ACC_COUNT_HIGH ||
                          idx == `TMRC_IDX_ACC_COUNT_LOW)) begin
        acc_clr = 2'b11;
      end
    end
  end

  always @(posedge clk_in) begin
    if (reset_in) begin
      channel_flag_reg          <= `TMRC_RESET_BYTE;
      counter_overflow_flag_reg <= 1'b0;
      accumulator_flag_reg      <= 2'b00;
    end else begin
      channel_flag_reg <= ((channel_flag_reg & ~chan_clr) |
                           (compare_hit & ~force_mask) | (capture_event_in & ~direction_reg)) &
                          IMPL;
      counter_overflow_flag_reg <= (counter_overflow_flag_reg & ~ovf_clr) | overflow;
      accumulator_flag_reg <= (accumulator_flag_reg & ~acc_clr) |
                              {acc_overflow_in, acc_edge_in};
    end
  end

  // Read mux; unmapped reads zero
  always @* begin
    rd_next = 32'h0000_0000;
    case (idx)
      `TMRC_IDX_DIRECTION:      rd_next[7:0] = direction_reg;
      `TMRC_IDX_OVR_MASK:       rd_next[7:0] = override_mask_reg;
      `TMRC_IDX_OVR_DATA:       rd_next[7:0] = override_data_reg;
      `TMRC_IDX_COUNT_HIGH:     rd_next[7:0] = main_counter_reg[15:8];
      `TMRC_IDX_COUNT_LOW:      rd_next[7:0] = main_counter_reg[7:0];
      `TMRC_IDX_SYSCTL_ONE:     rd_next[7:0] = system_control_one_reg;
      `TMRC_IDX_OVF_TOGGLE:     rd_next[7:0] = overflow_toggle_reg;
      `TMRC_IDX_ACTION_HI:      rd_next[7:0] = action_reg[15:8];
      `TMRC_IDX_ACTION_LO:      rd_next[7:0] = action_reg[7:0];
      `TMRC_IDX_SYSCTL_TWO:     rd_next[7:0] = system_control_two_reg;
      `TMRC_IDX_CHAN_FLAGS:     rd_next[7:0] = channel_flag_reg;
      `TMRC_IDX_OVF_FLAGS:      rd_next[7:0] = {counter_overflow_flag_reg, 7'h00};
      `TMRC_IDX_ACC_FLAGS:      rd_next[7:0] = {6'h00, accumulator_flag_reg};
      `TMRC_IDX_PIN_DISCONNECT: rd_next[7:0] = pin_disconnect_reg;
      `TMRC_IDX_PRECISION_PSC:  rd_next[7:0] = precision_prescaler_reg;
      `TMRC_IDX_MODE_STATUS:    rd_next[8:0] = phase;
      default: begin
        if (idx >= `TMRC_IDX_CHAN_FIRST && idx <= `TMRC_IDX_CHAN_LAST &&
            IMPL[idx[3:1]]) begin
          rd_next[7:0] = idx[0] ? compare_reg[idx[3:1]][7:0] : compare_reg[idx[3:1]][15:8];
        end
      end
    endcase
  end

  // Read data registered with the answer
  always @(posedge clk_in) begin
    if (reset_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (rd) begin
      wb_dat_out <= rd_next;
    end
  end
endmodule // tmrc_core

// >>> tb/tmrc_pin_load.sv
`timescale 1ns/1ps
// Far side of the timer port: pins with pull-ups
module tmrc_pin_load (
  input  wire logic [7:0] port_data_in,
  input  wire logic [7:0] port_drive_in,
  output wire logic [7:0] pin_level_out
);
  // undriven pins pulled high
  // A released pin shows the pull-up, never the stale data bit
  assign pin_level_out = (port_data_in & port_drive_in) | ~port_drive_in;
endmodule // tmrc_pin_load

// >>> tb/tmrc_core_monitor.sv
`timescale 1ns/1ps
module tmrc_core_monitor (
  input wire logic        clk_in,
  input wire logic        reset_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        special_mode_in,
  input wire logic        wait_mode_in,
  input wire logic        freeze_mode_in,
  input wire logic        acc_clock_out,
  input wire logic        counter_tick_out,
  input wire logic [15:0] main_counter_out
);
  logic en_reg;
  logic sw_reg;
  logic sf_reg;
  wire  take   = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  wire  sc1_wr = take & wb_we_in & wb_sel_in[0] & (wb_adr_in[7:2] == 6'h06);
  // Shadow of enable and stop bits, rebuilt from bus writes
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      {en_reg, sw_reg, sf_reg} <= 3'h0;
    end else if (sc1_wr) begin
      {en_reg, sw_reg, sf_reg} <= wb_dat_in[7:5];
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_read(ix);
    take && !wb_we_in && wb_adr_in[7:2] == ix;
  endsequence
  AST_ACK_TAKE: assert property (take |-> ##1 wb_ack_out ##1 !wb_ack_out)
    else $error("ack not a single pulse after take");
  AST_ACK_IDLE: assert property (!take |=> !wb_ack_out)
    else $error("ack without a request");
  AST_CNT_UP: assert property (
    counter_tick_out && !special_mode_in |=>
      main_counter_out == $past(main_counter_out) + 16'h0001)
    else $error("counter did not step up by one");
  AST_CNT_HOLD: assert property (
    !counter_tick_out && !special_mode_in |=> $stable(main_counter_out))
    else $error("counter moved without a tick");
  AST_HALT_EN: assert property (!en_reg |-> !counter_tick_out && !acc_clock_out)
    else $error("timer ran while disabled");
  AST_HALT_WAIT: assert property (
    sw_reg && wait_mode_in |-> !counter_tick_out && !acc_clock_out)
    else $error("timer ran in wait with stop set");
  AST_HALT_FRZ: assert property (sf_reg && freeze_mode_in |-> !counter_tick_out)
    else $error("counter ran in freeze with stop set");
  AST_SC1_LOW: assert property (s_read(6'h06) |=> wb_dat_out[2:0] == 3'h0)
    else $error("control low bits not zero");
  AST_FORCE_ZERO: assert property (s_read(6'h01) |=> wb_dat_out == 32'h0000_0000)
    else $error("force register read not zero");
endmodule // tmrc_core_monitor

bind tmrc_core tmrc_core_monitor i_tmrc_core_monitor (
  .clk_in(clk_in), .reset_in(reset_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out), .special_mode_in(special_mode_in),
  .wait_mode_in(wait_mode_in), .freeze_mode_in(freeze_mode_in),
  .acc_clock_out(acc_clock_out), .counter_tick_out(counter_tick_out),
  .main_counter_out(main_counter_out));

// >>> tb/timer_counter_core_override_tb.sv
`timescale 1ns/1ps
module timer_counter_core_override_tb;
  logic        clk_in;
  logic        reset_in;
  logic        cyc;
  logic        stb;
  logic        we;
  logic        spec;
  logic        waitm;
  logic        frz;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  wire  [31:0] rdat;
  wire         ack;
  wire         acc_clk;
  wire         tick;
  wire  [7:0]  pdata;
  wire  [7:0]  pdrive;
  wire  [7:0]  pins;
  wire  [15:0] cnt;
  int          fail_count;
  int          checked;
  int          wt;
  logic [7:0]  q;
  logic [7:0]  d;
  logic [7:0]  prev;
  logic [7:0]  r;
  logic [15:0] c0;
  logic [7:0]  cap;
  logic        acc_o;
  logic        acc_e;

  tmrc_core #(.CHANNELS(8)) i_tmrc_core (
    .clk_in(clk_in), .reset_in(reset_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .special_mode_in(spec),
    .wait_mode_in(waitm), .freeze_mode_in(frz), .capture_event_in(cap),
    .acc_overflow_in(acc_o), .acc_edge_in(acc_e), .port_data_out(pdata),
    .port_drive_out(pdrive), .acc_clock_out(acc_clk),
    .counter_tick_out(tick), .main_counter_out(cnt));
  tmrc_pin_load i_tmrc_pin_load (
    .port_data_in(pdata), .port_drive_in(pdrive), .pin_level_out(pins));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; held until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [5:0] ix, input logic [7:0] dv);
    int n;
    n = 0;
    {cyc, stb, we, adr, wdat} <= {2'b11, w, ix, 2'b00, 24'h00_0000, dv};
    @(posedge clk_in);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk_in);
      n++;
    end
    if (n == 50) fail_count++;
    q = rdat[7:0];
    {cyc, stb, we} <= 3'h0;
    @(posedge clk_in);
  endtask

  task automatic rd_chk(input logic [5:0] ix, input logic [7:0] exp);
    wb(1'b0, ix, 8'h00);
    chk({8'h00, q}, {8'h00, exp});
  endtask

  // Port after an overflow that is also a channel-7 event
  function automatic logic [7:0] exp_port(input logic [7:0] p, dv, m, t, dir, dis);
    logic [7:0] o;
    o = m & dir & ~dis;
    return ((p & ~o) | (dv & o)) ^ (t & dir & ~o);
  endfunction

  // Counter runs unless disabled or stopped by wait or freeze
  function automatic logic runs(input logic [7:0] v);
    return v[2] & ~(v[1] & v[3]) & ~(v[0] & v[4]);
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Watchdog well beyond the several hundred cycles the tests need
  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end

  initial begin
    {cyc, stb, we, adr, wdat, sel, spec, waitm, frz, cap, acc_o, acc_e} = '0;
    reset_in = 1'b1;
    fail_count = 0;
    checked = 0;
    void'($urandom(72));
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    sel <= 4'h1;
    // Reset state, reserved bits and the write-once precision bit
    rd_chk(6'h06, 8'h00);
    chk(cnt, 16'h0000);
    wb(1'b1, 6'h06, 8'h0F);
    rd_chk(6'h06, 8'h08);
    wb(1'b1, 6'h06, 8'h00);
    rd_chk(6'h06, 8'h08);
    // Counter writes: refused in normal mode, halted counter keeps them
    wb(1'b1, 6'h05, 8'h5A);
    rd_chk(6'h05, 8'h00);
    spec <= 1'b1;
    wb(1'b1, 6'h05, 8'h5A);
    repeat (20) @(posedge clk_in);
    chk(cnt, 16'h005A);
    wb(1'b1, 6'h24, 8'hFF);
    rd_chk(6'h24, 8'h00);
    rd_chk(6'h01, 8'h00);
    // Override setup: ch3 input, ch2 disconnected, ch1 both masked and toggling
    wb(1'b1, 6'h00, 8'hF7);
    wb(1'b1, 6'h2C, 8'h04);
    wb(1'b1, 6'h02, 8'h2E);
    rd_chk(6'h02, 8'h2E);
    wb(1'b1, 6'h07, 8'h83);
    rd_chk(6'h07, 8'h83);
    wb(1'b1, 6'h06, 8'h80);
    chk({8'h00, pdrive}, 16'h00F3);
    prev = 8'h00;
    for (int i = 0; i < 5; i++) begin
      d = $urandom();
      if (i == 0) d = 8'hFF;
      if (i == 1) d = 8'h00;
      wb(1'b1, 6'h03, d);
      rd_chk(6'h03, d);
      // coherent word load
      // Low byte first so the count cannot wrap between the two writes
      wb(1'b1, 6'h05, 8'hF0);
      wb(1'b1, 6'h04, 8'hFF);
      wt = 0;
      while (cnt !== 16'h0000 && wt < 200) begin
        @(posedge clk_in);
        wt++;
      end
      if (wt == 200) fail_count++;
      repeat (2) @(posedge clk_in);
      prev = exp_port(prev, d, 8'h2E, 8'h83, 8'hF7, 8'h04);
      chk({8'h00, pdata}, {8'h00, prev});
      chk({8'h00, pins}, {8'h00, (prev & 8'hF3) | 8'h0C});
    end
    // Overflow flag: kept on access without fast clear, cleared with it
    rd_chk(6'h0F, 8'h80);
    wb(1'b0, 6'h04, 8'h00);
    rd_chk(6'h0F, 8'h80);
    wb(1'b1, 6'h06, 8'h90);
    wb(1'b0, 6'h05, 8'h00);
    rd_chk(6'h0F, 8'h00);
    // Capture and accumulator flags, cleared by fast-clear accesses
    wb(1'b1, 6'h0E, 8'hFF);
    rd_chk(6'h0E, 8'h00);
    {cap, acc_o, acc_e} <= 10'h023;
    @(posedge clk_in);
    {cap, acc_o, acc_e} <= 10'h000;
    rd_chk(6'h0E, 8'h08);
    wb(1'b0, 6'h16, 8'h00);
    rd_chk(6'h0E, 8'h00);
    rd_chk(6'h21, 8'h03);
    wb(1'b0, 6'h22, 8'h00);
    rd_chk(6'h21, 8'h00);
    // Forced actions on ch0..2: toggle, drive low, drive high, no flag
    wb(1'b1, 6'h09, 8'h39);
    wb(1'b1, 6'h01, 8'h07);
    prev = {prev[7:3], 2'b10, ~prev[0]};
    chk({8'h00, pdata}, {8'h00, prev});
    rd_chk(6'h0E, 8'h00);
    // Divide of one keeps the prescaler phase at zero
    rd_chk(6'h30, 8'h00);
    // Random enable, wait and freeze combinations
    spec <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      r = $urandom();
      if (i == 0) r = 8'h1F;
      wb(1'b1, 6'h06, {r[2:0], 5'h00});
      waitm <= r[3];
      frz <= r[4];
      @(posedge clk_in);
      c0 = cnt;
      repeat (8) @(posedge clk_in);
      chk(16'(cnt !== c0), 16'(runs(r)));
    end
    give_verdict();
  end
endmodule // timer_counter_core_override_tb
